// ### rcr_regulator_config.sv
// Regulator configuration register bank with decoded regulator controls
// What this block does
// RL1 - Channel 2 bits 7:6 pick automatic, buck, boost or buck-boost operation.
// RL2 - Channel 2 bits 5:4 pick peak limit 1.000, 0.750, 0.500, 0.333 A.
// RL3 - Discharge bit set connects discharge resistor while channel 2 is disabled.
// RL4 - Enable codes 0 to 3 assign channel 2 to sequencer slots 0 to 3.
// RL5 - Enable codes 4,5 force channel 2 off; 6,7 force it on.
// RL6 - Host sets bias to normal power before enabling a buck-boost channel; bias control is outside this bank and the host model takes no such step.
// RL7 - Channel 0 alternate code gives 0.5V plus 25mV per step, saturating at 5.5V.
// RL8 - Linear regulator bit 7 adds a 1.325V offset when set.
// RL9 - Linear 7-bit code maps 0.5V to 3.675V in 25mV steps.
// RL10 - With offset set the linear range spans 1.825V to 5V.
// RL11 - All fields read back as written and load defaults at reset.
`timescale 1ns/1ps
module rcr_regulator_config #(
	parameter logic [7:0] CH2_CFG_DEFAULT = rcr_pkg::RCR_RST_CH2_CFG_B,
	parameter logic [7:0] LIN_VOLT_DEFAULT = rcr_pkg::RCR_RST_LIN_VOLT
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire logic [3:0] seq_slot_on,
	output logic [7:0] reg_rdata,
	output logic reg_rvalid,
	output rcr_pkg::rcr_conv_e conversion_mode_select,
	output logic [9:0] ch2_peak_current_limit,
	output logic ch2_enable,
	output logic ch2_discharge_on,
	output logic ch2_forced,
	output logic [12:0] ch0_alt_target_mv,
	output logic [12:0] linear_target_mv
);
	import rcr_pkg::*;

	logic [7:0] ch2_cfg;
	logic [7:0] ch0_alt;
	logic [7:0] lin_volt;
	logic wr_ch2;
	logic wr_ch0;
	logic wr_lin;
	logic [1:0] mode_fld;
	logic [1:0] peak_fld;
	logic ch2_discharge_enable;
	logic [2:0] ch2_sequence_slot_select;
	logic [6:0] linear_target_code;
	logic linear_offset_select;
	logic next_enable;
	logic [12:0] next_ch0_mv;
	logic [12:0] next_lin_mv;

	// ==========================================
	// Address decode and storage
	always_comb
	begin
		wr_ch2 = 1'b0;
		wr_ch0 = 1'b0;
		wr_lin = 1'b0;
		if (reg_addr == RCR_OFS_CH2_CFG_B)
			wr_ch2 = reg_wr;
		else if (reg_addr == RCR_OFS_CH0_ALT)
			wr_ch0 = reg_wr;
		else if (reg_addr == RCR_OFS_LIN_VOLT)
			wr_lin = reg_wr;
	end

	rcr_reg8 #(.RESET_VAL(CH2_CFG_DEFAULT)) u_ch2 (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr(wr_ch2), // [RL11]
		.wdata(reg_wdata),
		.q(ch2_cfg)
	);

	rcr_reg8 #(.RESET_VAL(RCR_RST_CH0_ALT)) u_ch0 (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr(wr_ch0), // [RL11]
		.wdata(reg_wdata),
		.q(ch0_alt)
	);

	rcr_reg8 #(.RESET_VAL(LIN_VOLT_DEFAULT)) u_lin (
		.clk_sys(clk_sys),
		.rst(rst),
		.wr(wr_lin), // [RL11]
		.wdata(reg_wdata),
		.q(lin_volt)
	);

	// ==========================================
	// Read port
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			reg_rdata <= RCR_RST_RDATA;
			reg_rvalid <= 1'b0;
		end
		else
		begin
			reg_rvalid <= reg_rd;
			if (reg_rd)
			begin
				if (reg_addr == RCR_OFS_CH2_CFG_B)
					reg_rdata <= ch2_cfg; // [RL11]
				else if (reg_addr == RCR_OFS_CH0_ALT)
					reg_rdata <= ch0_alt; // [RL11]
				else if (reg_addr == RCR_OFS_LIN_VOLT)
					reg_rdata <= lin_volt; // [RL11]
				else
					reg_rdata <= RCR_RST_RDATA;
			end
		end
	end

	// ==========================================
	// Field extraction
	assign mode_fld = ch2_cfg[RCR_MODE_HI:RCR_MODE_LO];
	assign peak_fld = ch2_cfg[RCR_PEAK_HI:RCR_PEAK_LO];
	assign ch2_discharge_enable = ch2_cfg[RCR_DISCH_BIT];
	assign ch2_sequence_slot_select = ch2_cfg[RCR_SLOT_HI:RCR_SLOT_LO];
	assign linear_offset_select = lin_volt[RCR_LOFS_BIT];
	assign linear_target_code = lin_volt[RCR_LCODE_HI:0];

	// ==========================================
	// Channel 2 enable decode
	always_comb
	begin
		if (ch2_sequence_slot_select[RCR_FORCE_BIT])
			next_enable = ch2_sequence_slot_select[RCR_FORCE_ON_BIT]; // [RL5]
		else
			next_enable = seq_slot_on[ch2_sequence_slot_select[1:0]]; // [RL4]
	end

	// ==========================================
	// Voltage arithmetic
	always_comb
	begin
		if (ch0_alt >= RCR_CODE_SAT)
			next_ch0_mv = RCR_V_MAX_MV; // [RL7]
		else
			next_ch0_mv = RCR_V_BASE_MV + 13'(ch0_alt) * 13'h019; // [RL7]
		next_lin_mv = RCR_V_BASE_MV + 13'(linear_target_code) * 13'h019; // [RL9]
		if (linear_offset_select)
			next_lin_mv = next_lin_mv + RCR_V_OFS_MV; // [RL8] [RL10]
	end

	// ==========================================
	// Channel 2 control outputs
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			conversion_mode_select <= RCR_CONV_AUTO;
			ch2_peak_current_limit <= RCR_PEAK_MA_0;
			ch2_enable <= 1'b0;
			ch2_discharge_on <= 1'b0;
			ch2_forced <= 1'b0;
		end
		else
		begin
			case (mode_fld) // [RL1]
				RCR_MODE_AUTO: conversion_mode_select <= RCR_CONV_AUTO;
				RCR_MODE_BUCK: conversion_mode_select <= RCR_CONV_BUCK;
				RCR_MODE_BOOST: conversion_mode_select <= RCR_CONV_BOOST;
				default: conversion_mode_select <= RCR_CONV_BUCKBOOST;
			endcase
			case (peak_fld) // [RL2]
				2'h0: ch2_peak_current_limit <= RCR_PEAK_MA_0;
				2'h1: ch2_peak_current_limit <= RCR_PEAK_MA_1;
				2'h2: ch2_peak_current_limit <= RCR_PEAK_MA_2;
				default: ch2_peak_current_limit <= RCR_PEAK_MA_3;
			endcase
			ch2_enable <= next_enable;
			ch2_discharge_on <= ch2_discharge_enable & ~next_enable; // [RL3]
			ch2_forced <= ch2_sequence_slot_select[RCR_FORCE_BIT];
		end
	end

	// ==========================================
	// Voltage target outputs
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
		begin
			ch0_alt_target_mv <= RCR_V_BASE_MV;
			linear_target_mv <= RCR_V_BASE_MV;
		end
		else
		begin
			ch0_alt_target_mv <= next_ch0_mv;
			linear_target_mv <= next_lin_mv;
		end
	end

	// ==========================================
	// Assertions
	sequence s_wr_ch0;
		reg_wr && reg_addr == RCR_OFS_CH0_ALT && !reg_rd;
	endsequence

	sequence s_rd_ch0;
		reg_rd && !reg_wr && reg_addr == RCR_OFS_CH0_ALT;
	endsequence

	property p_readback;
		@(posedge clk_sys) disable iff (rst)
		s_wr_ch0 ##1 s_rd_ch0 |=> reg_rvalid && reg_rdata == $past(reg_wdata, 2);
	endproperty
	a_readback: assert property (p_readback) else $error("readback mismatch"); // [RL11]

	property p_mode;
		@(posedge clk_sys) disable iff (rst)
		!rst |=> conversion_mode_select == rcr_conv_e'(4'h1 << $past(mode_fld));
	endproperty
	a_mode: assert property (p_mode) else $error("mode decode wrong"); // [RL1]

	property p_peak;
		@(posedge clk_sys) disable iff (rst)
		peak_fld == 2'h3 |=> ch2_peak_current_limit == 10'h14D;
	endproperty
	a_peak: assert property (p_peak) else $error("peak limit wrong"); // [RL2]

	property p_discharge;
		@(posedge clk_sys) disable iff (rst)
		ch2_discharge_on |-> !ch2_enable && $past(ch2_discharge_enable);
	endproperty
	a_discharge: assert property (p_discharge) else $error("discharge while on"); // [RL3]

	property p_slot;
		@(posedge clk_sys) disable iff (rst)
		!rst && !ch2_sequence_slot_select[2]
			|=> ch2_enable == $past(seq_slot_on[ch2_sequence_slot_select[1:0]]);
	endproperty
	a_slot: assert property (p_slot) else $error("slot enable wrong"); // [RL4]

	property p_force;
		@(posedge clk_sys) disable iff (rst)
		ch2_sequence_slot_select[2] |=> ch2_forced && ch2_enable == $past(ch2_cfg[1]);
	endproperty
	a_force: assert property (p_force) else $error("force wrong"); // [RL5]

	property p_ch0_sat;
		@(posedge clk_sys) disable iff (rst)
		ch0_alt >= 8'hC8 |=> ch0_alt_target_mv == 13'h157C;
	endproperty
	a_ch0_sat: assert property (p_ch0_sat) else $error("ch0 not saturated"); // [RL7]

	property p_ch0_lin;
		@(posedge clk_sys) disable iff (rst)
		!rst && ch0_alt == 8'h14 |=> ch0_alt_target_mv == 13'h3E8;
	endproperty
	a_ch0_lin: assert property (p_ch0_lin) else $error("ch0 slope wrong"); // [RL7]

	property p_lin_top;
		@(posedge clk_sys) disable iff (rst)
		lin_volt == 8'h7F |=> linear_target_mv == 13'hE5B;
	endproperty
	a_lin_top: assert property (p_lin_top) else $error("linear top wrong"); // [RL9]

	property p_lin_ofs;
		@(posedge clk_sys) disable iff (rst)
		lin_volt == 8'h80 |=> linear_target_mv == 13'h721;
	endproperty
	a_lin_ofs: assert property (p_lin_ofs) else $error("offset base wrong"); // [RL8]

	property p_lin_ofs_top;
		@(posedge clk_sys) disable iff (rst)
		lin_volt == 8'hFF |=> linear_target_mv == 13'h1388;
	endproperty
	a_lin_ofs_top: assert property (p_lin_ofs_top) else $error("offset top wrong"); // [RL10]
endmodule

// ### rcr_pkg.sv
// Register map, field layout and decode constants for the regulator config bank
package rcr_pkg;
	// ==========================================
	// Register offsets
	localparam logic [7:0] RCR_OFS_CH2_CFG_B = 8'h2E;
	localparam logic [7:0] RCR_OFS_CH0_ALT = 8'h2F;
	localparam logic [7:0] RCR_OFS_LIN_VOLT = 8'h38;
	// ==========================================
	// Field positions
	localparam int RCR_MODE_HI = 7;
	localparam int RCR_MODE_LO = 6;
	localparam int RCR_PEAK_HI = 5;
	localparam int RCR_PEAK_LO = 4;
	localparam int RCR_DISCH_BIT = 3;
	localparam int RCR_SLOT_HI = 2;
	localparam int RCR_SLOT_LO = 0;
	localparam int RCR_FORCE_BIT = 2;
	localparam int RCR_FORCE_ON_BIT = 1;
	localparam int RCR_LOFS_BIT = 7;
	localparam int RCR_LCODE_HI = 6;
	// ==========================================
	// Reset values
	localparam logic [7:0] RCR_RST_CH0_ALT = 8'h14;
	localparam logic [7:0] RCR_RST_CH2_CFG_B = 8'h00;
	localparam logic [7:0] RCR_RST_LIN_VOLT = 8'h00;
	localparam logic [7:0] RCR_RST_RDATA = 8'h00;
	// ==========================================
	// Mode codes
	localparam logic [1:0] RCR_MODE_AUTO = 2'h0;
	localparam logic [1:0] RCR_MODE_BUCK = 2'h1;
	localparam logic [1:0] RCR_MODE_BOOST = 2'h2;
	localparam logic [1:0] RCR_MODE_BUCKBOOST = 2'h3;
	typedef enum logic [3:0]
	{
		RCR_CONV_AUTO = 4'h1,
		RCR_CONV_BUCK = 4'h2,
		RCR_CONV_BOOST = 4'h4,
		RCR_CONV_BUCKBOOST = 4'h8
	} rcr_conv_e;
	// ==========================================
	// Peak current limits in mA
	localparam logic [9:0] RCR_PEAK_MA_0 = 10'h3E8;
	localparam logic [9:0] RCR_PEAK_MA_1 = 10'h2EE;
	localparam logic [9:0] RCR_PEAK_MA_2 = 10'h1F4;
	localparam logic [9:0] RCR_PEAK_MA_3 = 10'h14D;
	// ==========================================
	// Voltage transfer in mV
	localparam logic [12:0] RCR_V_BASE_MV = 13'h01F4;
	localparam logic [12:0] RCR_V_MAX_MV = 13'h157C;
	localparam logic [12:0] RCR_V_OFS_MV = 13'h052D;
	localparam logic [7:0] RCR_CODE_SAT = 8'hC8;
endpackage

// ### rcr_reg8.sv
// One 8-bit read/write configuration register with a fixed power-on value
`timescale 1ns/1ps
module rcr_reg8 #(
	parameter logic [7:0] RESET_VAL = 8'h00
) (
	input wire logic clk_sys,
	input wire logic rst,
	input wire logic wr,
	input wire logic [7:0] wdata,
	output logic [7:0] q
);
	// ==========================================
	// Storage
	always_ff @(posedge clk_sys or posedge rst)
	begin
		if (rst)
			q <= RESET_VAL;
		else if (wr)
			q <= wdata;
	end
endmodule

// ### rcr_host.sv
// Host model driving register strobes into the regulator config bank
`timescale 1ns/1ps
module rcr_host (
	input wire logic clk_sys,
	output logic [7:0] reg_addr,
	output logic [7:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd
);
	// ==========================================
	// Idle bus at time zero
	initial
	begin
		reg_addr = 8'h00;
		reg_wdata = 8'h00;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// ==========================================
	// One strobe, held over its sampling edge
	// Bias control sits outside this bank, so no step precedes an enable
	task automatic access(input logic is_wr, input logic [7:0] addr, input logic [7:0] data);
		reg_addr <= addr;
		reg_wdata <= is_wr ? data : ~data;
		reg_wr <= is_wr;
		reg_rd <= ~is_wr;
		@(posedge clk_sys);
	endtask
	// Strobes low, idle buses toggle each cycle
	task automatic idle(input int n);
		reg_wr <= 1'b0;
		reg_rd <= 1'b0;
		repeat (n)
		begin
			reg_addr <= ~reg_addr;
			reg_wdata <= ~reg_wdata;
			@(posedge clk_sys);
		end
	endtask
endmodule

// ### testbench.sv
// Self-checking bench for the regulator config register bank
`timescale 1ns/1ps
module testbench;
	import rcr_pkg::*;
	localparam int LIMIT = 3000;
	logic clk_sys = 1'b0;
	logic rst = 1'b1;
	logic [3:0] seq_slot_on = 4'h0;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic reg_wr, reg_rd, reg_rvalid, ch2_enable, ch2_discharge_on, ch2_forced;
	rcr_conv_e conversion_mode_select;
	logic [9:0] ch2_peak_current_limit;
	logic [12:0] ch0_alt_target_mv, linear_target_mv;
	logic [7:0] sh_cfg, sh_alt, sh_lin;
	logic [7:0] exp_q[$];
	logic [9:0] peaks [4] = '{RCR_PEAK_MA_0, RCR_PEAK_MA_1, RCR_PEAK_MA_2, RCR_PEAK_MA_3};
	logic [7:0] edges [6] = '{8'h00, 8'h7F, 8'h80, 8'hC7, 8'hC8, 8'hFF};
	logic [31:0] seed = 32'h94786BFB;
	logic [31:0] r;
	int err_count = 0;
	int compares = 0;
	int cycles = 0;
	always #2.5 clk_sys = ~clk_sys;
	rcr_regulator_config rcr_regulator_config_i (.clk_sys(clk_sys), .rst(rst),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
		.seq_slot_on(seq_slot_on), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
		.conversion_mode_select(conversion_mode_select),
		.ch2_peak_current_limit(ch2_peak_current_limit), .ch2_enable(ch2_enable),
		.ch2_discharge_on(ch2_discharge_on), .ch2_forced(ch2_forced),
		.ch0_alt_target_mv(ch0_alt_target_mv), .linear_target_mv(linear_target_mv));
	rcr_host rcr_host_i (.clk_sys(clk_sys), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd));
	// ==========================================
	// Compare, verdict, random source
	task automatic check(input string name, input logic [12:0] seen, input logic [12:0] exp);
		compares++;
		if (seen !== exp)
		begin
			err_count++;
			$display("wrong value %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic give_verdict();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
		return seed;
	endfunction
	// ==========================================
	// Register access with expected results
	task automatic rd(input logic [7:0] addr, input logic [7:0] exp);
		exp_q.push_back(exp);
		rcr_host_i.access(1'b0, addr, 8'h00);
	endtask
	task automatic check_outputs();
		logic on;
		logic [12:0] alt_mv;
		rcr_host_i.idle(1);
		@(negedge clk_sys);
		on = sh_cfg[2] ? sh_cfg[1] : seq_slot_on[sh_cfg[1:0]];
		alt_mv = (sh_alt >= RCR_CODE_SAT) ? RCR_V_MAX_MV : RCR_V_BASE_MV + 13'h019 * sh_alt;
		check("mode", 13'(conversion_mode_select), 13'h001 << sh_cfg[7:6]);
		check("peak", 13'(ch2_peak_current_limit), 13'(peaks[sh_cfg[5:4]]));
		check("enable", 13'(ch2_enable), 13'(on));
		check("forced", 13'(ch2_forced), 13'(sh_cfg[2]));
		check("discharge", 13'(ch2_discharge_on), 13'(sh_cfg[3] & ~on));
		check("alt_mv", ch0_alt_target_mv, alt_mv);
		check("lin_mv", linear_target_mv, RCR_V_BASE_MV + 13'h019 * sh_lin[6:0]
			+ (sh_lin[7] ? RCR_V_OFS_MV : 13'h000));
		// Hand back on a rising edge
		@(posedge clk_sys);
	endtask
	task automatic wr_chk(input logic [7:0] addr, input logic [7:0] data);
		rcr_host_i.access(1'b1, addr, data);
		case (addr)
			RCR_OFS_CH2_CFG_B: sh_cfg = data;
			RCR_OFS_CH0_ALT: sh_alt = data;
			default: sh_lin = data;
		endcase
		rd(addr, data);
		check_outputs();
	endtask
	task automatic reset_chk();
		sh_cfg = RCR_RST_CH2_CFG_B;
		sh_alt = 8'h14;
		sh_lin = RCR_RST_LIN_VOLT;
		rd(RCR_OFS_CH2_CFG_B, sh_cfg);
		rd(RCR_OFS_CH0_ALT, sh_alt);
		rd(RCR_OFS_LIN_VOLT, sh_lin);
		check_outputs();
	endtask
	// ==========================================
	// Read results against the oldest note
	always @(negedge clk_sys)
	begin
		if (reg_rvalid === 1'b1)
		begin
			if (exp_q.size() == 0)
				check("rvalid", 13'h001, 13'h000);
			else
				check("rdata", 13'(reg_rdata), 13'(exp_q.pop_front()));
		end
	end
	always @(posedge clk_sys)
	begin
		cycles <= cycles + 1;
		if (cycles == LIMIT)
		begin
			err_count++;
			give_verdict();
		end
	end
	// ==========================================
	// Main sequence
	initial
	begin
		repeat (6) @(posedge clk_sys);
		rst <= 1'b0;
		reset_chk();
		for (int i = 0; i < 4; i++)
			wr_chk(RCR_OFS_CH2_CFG_B, {i[1:0], ~i[1:0], 4'h6});
		for (int i = 0; i < 32; i++)
		begin
			r = rnd();
			seq_slot_on <= r[3:0];
			wr_chk(RCR_OFS_CH2_CFG_B, {r[7:4], i[0], i[3:1]});
		end
		for (int i = 0; i < 14; i++)
		begin
			r = rnd();
			if (i < 6)
				r[15:0] = {edges[i], edges[i]};
			wr_chk(RCR_OFS_CH0_ALT, r[7:0]);
			wr_chk(RCR_OFS_LIN_VOLT, r[15:8]);
		end
		rcr_host_i.access(1'b1, 8'h30, 8'hA5);
		rd(8'h30, 8'h00);
		rd(RCR_OFS_CH0_ALT, sh_alt);
		check_outputs();
		rst <= 1'b1;
		rcr_host_i.idle(2);
		rst <= 1'b0;
		reset_chk();
		rcr_host_i.idle(2);
		check("pending", 13'(exp_q.size()), 13'h000);
		give_verdict();
	end
endmodule
